// ===== inc/reset_seq_pkg.sv
// Constants shared by the reset and watchdog sequencer
package reset_seq_pkg;
    // Core clock rate
    localparam real CLK_FREQ_MHZ   = 250.0;
    // Timing figures in their own units
    localparam real RC_STAB_US     = 100.0;
    localparam real XTAL_STAB_MS   = 0.75;
    localparam real SW_PULSE_US    = 1.0;
    localparam real LINE_RISE_US   = 100.0;
    // Least times round up, longest times round down
    localparam int  RC_STAB_CYC    = int'($ceil(RC_STAB_US * CLK_FREQ_MHZ));
    localparam int  XTAL_STAB_CYC  = int'($ceil(XTAL_STAB_MS * 1000.0 * CLK_FREQ_MHZ));
    localparam int  SW_PULSE_CYC   = int'($ceil(SW_PULSE_US * CLK_FREQ_MHZ));
    localparam int  LINE_RISE_CYC  = int'($floor(LINE_RISE_US * CLK_FREQ_MHZ));
    localparam int  CNT_W          = 18;
    // Register offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_WDOG   = 8'h04;
    localparam logic [7:0] ADDR_BOD    = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    // Control register fields
    localparam int  CTRL_SW_RST    = 0;
    localparam int  CTRL_SW_DRIVE  = 1;
    localparam int  CTRL_LINE_DRV  = 2;
    // Watchdog register fields
    localparam int  WDOG_EN        = 0;
    localparam int  WDOG_SEL_LSB   = 4;
    localparam int  WDOG_RESTART   = 8;
    localparam int  WDOG_SEL_W     = 4;
    localparam logic [3:0] WDOG_SEL_MAX = 4'hb;
    localparam int  WDOG_BASE_SH   = 8;
    localparam int  WDOG_CNT_W     = 20;
    // Brown-out register fields
    localparam int  BOD_THR_LSB    = 0;
    localparam int  BOD_RST_EN     = 4;
    localparam int  BOD_FALL_EN    = 5;
    localparam int  BOD_RISE_EN    = 6;
    // Threshold codes
    localparam logic [1:0] BOD_THR_2V0 = 2'h0;
    localparam logic [1:0] BOD_THR_2V3 = 2'h1;
    localparam logic [1:0] BOD_THR_2V7 = 2'h2;
    localparam logic [1:0] BOD_THR_3V0 = 2'h3;
    // Status register fields
    localparam int  ST_CAUSE_LSB   = 0;
    localparam int  ST_WDOG_FIRED  = 4;
    localparam int  ST_BOD_BELOW   = 5;
    localparam int  ST_LINE_LVL    = 6;
    localparam int  ST_RUNNING     = 7;
    // Reset cause codes
    localparam logic [2:0] CAUSE_POR   = 3'h0;
    localparam logic [2:0] CAUSE_EXT   = 3'h1;
    localparam logic [2:0] CAUSE_SW    = 3'h2;
    localparam logic [2:0] CAUSE_WDOG  = 3'h3;
    localparam logic [2:0] CAUSE_BOD   = 3'h4;
    localparam logic [2:0] CAUSE_LINE  = 3'h5;
    // CPU start address after reset
    localparam logic [7:0] RESET_VECTOR = 8'h38;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_HOLD,
        ST_RC_WAIT,
        ST_XTAL_WAIT,
        ST_RUN,
        ST_SW_PULSE
    } seq_state_t;
endpackage

// ===== src/reset_watchdog_sequencer.sv
// Chip reset sequencer with reset line control, brown-out and watchdog
module reset_watchdog_sequencer #(
    parameter int RC_CYC       = reset_seq_pkg::RC_STAB_CYC,
    parameter int XTAL_CYC     = reset_seq_pkg::XTAL_STAB_CYC,
    parameter int RISE_CYC     = reset_seq_pkg::LINE_RISE_CYC,
    parameter int SW_CYC       = reset_seq_pkg::SW_PULSE_CYC,
    parameter int LINE_MIN_CYC = 8
) (
    // Clock, reset and enable
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // Supply monitors
    input  wire logic        i_por_ok,
    input  wire logic        i_bod_below,
    input  wire logic [1:0]  i_fuse_bod_thr,
    // Shared reset line
    input  wire logic        i_line_in,
    output logic             o_line_out,
    output logic             o_line_oe,
    // Power state and timebase
    input  wire logic        i_tick32k,
    input  wire logic        i_sleep,
    input  wire logic        i_debug_stall,
    input  wire logic        i_wake,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    // Chip control outputs
    output logic             o_xtal_en,
    output logic             o_logic_pwr_en,
    output logic             o_core_rst_n,
    output logic             o_ram_invalid,
    output logic [7:0]       o_boot_vector,
    output logic [1:0]       o_bod_thr,
    output logic             o_bod_irq
);

    localparam int CW = reset_seq_pkg::CNT_W;
    localparam int WW = reset_seq_pkg::WDOG_CNT_W;

    // Watchdog terminal count for a period select
    function automatic logic [WW-1:0] wdog_limit(input logic [3:0] sel);
        logic [WW-1:0] one;
        one = {{(WW-1){1'b0}}, 1'b1};
        return (one << (5'(sel) + 5'(reset_seq_pkg::WDOG_BASE_SH))) - one;
    endfunction

    // Counter terminal test
    function automatic logic at_end(input logic [CW-1:0] cnt, input int lim);
        return cnt == CW'(lim - 1);
    endfunction

    reset_seq_pkg::seq_state_t state_reg;
    reset_seq_pkg::seq_state_t state_next;

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] rise_cnt_reg;
    logic [7:0]    ext_cnt_reg;
    logic [2:0]    cause_reg;
    logic [2:0]    cause_next;
    logic          cause_load;
    logic          line_oe_reg;
    logic          rise_act_reg;
    logic          sync1_reg;
    logic          sync2_reg;
    logic          sw_drive_reg;
    logic          line_drv_reg;
    logic          wdog_en_reg;
    logic [3:0]    wdog_sel_reg;
    logic [WW-1:0] wdog_cnt_reg;
    logic          wdog_fired_reg;
    logic [1:0]    bod_thr_reg;
    logic          bod_rst_en_reg;
    logic          bod_fall_en_reg;
    logic          bod_rise_en_reg;
    logic          bod_prev_reg;
    logic          bod_irq_reg;
    logic          ram_inv_reg;
    logic [31:0]   rdata_reg;

    // Decodes
    wire running    = state_reg == reset_seq_pkg::ST_RUN;
    wire in_seq     = (state_reg == reset_seq_pkg::ST_HOLD) ||
                      (state_reg == reset_seq_pkg::ST_RC_WAIT) ||
                      (state_reg == reset_seq_pkg::ST_XTAL_WAIT);
    wire wr_ctrl    = i_wr && running && (i_addr == reset_seq_pkg::ADDR_CTRL);
    wire wr_wdog    = i_wr && running && (i_addr == reset_seq_pkg::ADDR_WDOG);
    wire wr_bod     = i_wr && running && (i_addr == reset_seq_pkg::ADDR_BOD);
    wire wr_status  = i_wr && running && (i_addr == reset_seq_pkg::ADDR_STATUS);
    wire sw_req     = wr_ctrl && i_wdata[reset_seq_pkg::CTRL_SW_RST];
    wire wdog_kick  = wr_wdog && i_wdata[reset_seq_pkg::WDOG_RESTART];
    wire [3:0] wsel_in  = i_wdata[reset_seq_pkg::WDOG_SEL_LSB +: reset_seq_pkg::WDOG_SEL_W];
    wire [3:0] wsel_lim = (wsel_in > reset_seq_pkg::WDOG_SEL_MAX) ?
                          reset_seq_pkg::WDOG_SEL_MAX : wsel_in;

    // External line low, ignoring our own drive and the rise window
    wire ext_low    = !i_line_in && !line_oe_reg && !rise_act_reg;
    wire line_rst   = ext_cnt_reg == 8'(LINE_MIN_CYC);
    wire rise_tmo   = rise_act_reg && !i_line_in && at_end(rise_cnt_reg, RISE_CYC);

    // Brown-out monitor is awake or in doze only
    wire bod_live   = running && !i_sleep;
    wire bod_rst    = bod_live && bod_rst_en_reg && i_bod_below;
    wire bod_fall   = bod_live && i_bod_below && !bod_prev_reg && bod_fall_en_reg;
    wire bod_rise   = bod_live && !i_bod_below && bod_prev_reg && bod_rise_en_reg;

    // Watchdog stalls in sleep and under the debugger
    wire wdog_run   = running && wdog_en_reg && !i_sleep && !i_debug_stall;
    wire wdog_exp   = wdog_run && i_tick32k &&
                      (wdog_cnt_reg == wdog_limit(wdog_sel_reg));

    // Conditions that keep the chip in reset
    wire hold_cause = !i_por_ok || line_rst || i_bod_below;

    // Line drive: power-on sequence, software pulse, or software hold
    wire oe_next    = (in_seq && (cause_reg == reset_seq_pkg::CAUSE_POR)) ||
                      (state_reg == reset_seq_pkg::ST_SW_PULSE) ||
                      (running && line_drv_reg);

    // Asynchronous assertion of internal reset
    wire core_arst_n = i_rst_n && i_por_ok && running;

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        cause_next = cause_reg;
        cause_load = 1'b0;
        case (state_reg)
            reset_seq_pkg::ST_HOLD: begin
                if (!hold_cause) begin
                    state_next = reset_seq_pkg::ST_RC_WAIT;
                end
            end
            reset_seq_pkg::ST_RC_WAIT: begin
                if (hold_cause) begin
                    state_next = reset_seq_pkg::ST_HOLD;
                end else if (at_end(cnt_reg, RC_CYC)) begin
                    state_next = reset_seq_pkg::ST_XTAL_WAIT;
                end
            end
            reset_seq_pkg::ST_XTAL_WAIT: begin
                if (hold_cause) begin
                    state_next = reset_seq_pkg::ST_HOLD;
                end else if (at_end(cnt_reg, XTAL_CYC)) begin
                    state_next = reset_seq_pkg::ST_RUN;
                end
            end
            reset_seq_pkg::ST_RUN: begin
                cause_load = 1'b1;
                if (!i_por_ok) begin
                    cause_next = reset_seq_pkg::CAUSE_POR;
                    state_next = reset_seq_pkg::ST_HOLD;
                end else if (line_rst) begin
                    cause_next = reset_seq_pkg::CAUSE_EXT;
                    state_next = reset_seq_pkg::ST_HOLD;
                end else if (bod_rst) begin
                    cause_next = reset_seq_pkg::CAUSE_BOD;
                    state_next = reset_seq_pkg::ST_HOLD;
                end else if (wdog_exp) begin
                    cause_next = reset_seq_pkg::CAUSE_WDOG;
                    state_next = reset_seq_pkg::ST_HOLD;
                end else if (rise_tmo) begin
                    cause_next = reset_seq_pkg::CAUSE_LINE;
                    state_next = reset_seq_pkg::ST_HOLD;
                end else if (sw_req) begin
                    cause_next = reset_seq_pkg::CAUSE_SW;
                    state_next = i_wdata[reset_seq_pkg::CTRL_SW_DRIVE] || sw_drive_reg ?
                                 reset_seq_pkg::ST_SW_PULSE : reset_seq_pkg::ST_HOLD;
                end else begin
                    cause_load = 1'b0;
                end
            end
            reset_seq_pkg::ST_SW_PULSE: begin
                if (at_end(cnt_reg, SW_CYC)) begin
                    state_next = reset_seq_pkg::ST_HOLD;
                end
            end
            default: begin
                state_next = reset_seq_pkg::ST_HOLD;
            end
        endcase
    end

    // Sequencer state, phase counter and cause
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= reset_seq_pkg::ST_HOLD;
            cnt_reg   <= '0;
            cause_reg <= reset_seq_pkg::CAUSE_POR;
        end else if (i_ce) begin
            state_reg <= state_next;
            cnt_reg   <= (state_next != state_reg) ? '0 : cnt_reg + CW'(1);
            if (cause_load) begin
                cause_reg <= cause_next;
            end
        end
    end

    // Release of internal reset passes a two-flop synchroniser
    always_ff @(posedge i_core_clk or negedge core_arst_n) begin
        if (!core_arst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (i_ce) begin
            sync1_reg <= 1'b1;
            sync2_reg <= sync1_reg;
        end
    end

    // Line drive and rise supervision
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_oe_reg  <= 1'b0;
            rise_act_reg <= 1'b0;
            rise_cnt_reg <= '0;
        end else if (i_ce) begin
            line_oe_reg <= oe_next;
            if (line_oe_reg && !oe_next) begin
                rise_act_reg <= 1'b1;
                rise_cnt_reg <= '0;
            end else if (rise_act_reg && (i_line_in || rise_tmo || oe_next)) begin
                rise_act_reg <= 1'b0;
            end else if (rise_act_reg) begin
                rise_cnt_reg <= rise_cnt_reg + CW'(1);
            end
        end
    end

    // Low-pulse filter on the external reset line
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_cnt_reg <= '0;
        end else if (i_ce) begin
            if (!ext_low) begin
                ext_cnt_reg <= '0;
            end else if (!line_rst) begin
                ext_cnt_reg <= ext_cnt_reg + 8'h01;
            end
        end
    end

    // Control and brown-out configuration, defaults while in reset
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sw_drive_reg    <= 1'b1;
            line_drv_reg    <= 1'b0;
            bod_thr_reg     <= reset_seq_pkg::BOD_THR_2V3;
            bod_rst_en_reg  <= 1'b1;
            bod_fall_en_reg <= 1'b0;
            bod_rise_en_reg <= 1'b0;
        end else if (i_ce) begin
            if (!running) begin
                sw_drive_reg    <= 1'b1;
                line_drv_reg    <= 1'b0;
                bod_thr_reg     <= i_fuse_bod_thr;
                bod_rst_en_reg  <= 1'b1;
                bod_fall_en_reg <= 1'b0;
                bod_rise_en_reg <= 1'b0;
            end else begin
                if (wr_ctrl) begin
                    sw_drive_reg <= i_wdata[reset_seq_pkg::CTRL_SW_DRIVE];
                    line_drv_reg <= i_wdata[reset_seq_pkg::CTRL_LINE_DRV];
                end
                if (wr_bod) begin
                    bod_thr_reg     <= i_wdata[reset_seq_pkg::BOD_THR_LSB +: 2];
                    bod_rst_en_reg  <= i_wdata[reset_seq_pkg::BOD_RST_EN];
                    bod_fall_en_reg <= i_wdata[reset_seq_pkg::BOD_FALL_EN];
                    bod_rise_en_reg <= i_wdata[reset_seq_pkg::BOD_RISE_EN];
                end
            end
        end
    end

    // Brown-out edge events
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bod_prev_reg <= 1'b0;
            bod_irq_reg  <= 1'b0;
        end else if (i_ce) begin
            bod_prev_reg <= i_bod_below;
            bod_irq_reg  <= bod_fall || bod_rise;
        end
    end

    // Watchdog configuration and counter
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wdog_en_reg  <= 1'b1;
            wdog_sel_reg <= reset_seq_pkg::WDOG_SEL_MAX;
            wdog_cnt_reg <= '0;
        end else if (i_ce) begin
            if (!running || i_wake) begin
                wdog_en_reg  <= 1'b1;
                wdog_sel_reg <= reset_seq_pkg::WDOG_SEL_MAX;
                wdog_cnt_reg <= '0;
            end else if (wr_wdog) begin
                wdog_en_reg  <= i_wdata[reset_seq_pkg::WDOG_EN];
                wdog_sel_reg <= wsel_lim;
                if (wdog_kick) begin
                    wdog_cnt_reg <= '0;
                end
            end else if (wdog_run && i_tick32k) begin
                wdog_cnt_reg <= wdog_cnt_reg + WW'(1);
            end
        end
    end

    // Watchdog flag kept across chip reset; set wins over clear
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wdog_fired_reg <= 1'b0;
        end else if (i_ce) begin
            if (wdog_exp) begin
                wdog_fired_reg <= 1'b1;
            end else if (wr_status && i_wdata[reset_seq_pkg::ST_WDOG_FIRED]) begin
                wdog_fired_reg <= 1'b0;
            end
        end
    end

    // RAM invalid marker across reset sequence
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ram_inv_reg <= 1'b1;
        end else if (i_ce) begin
            ram_inv_reg <= !running;
        end
    end

    // Read mux
    wire [31:0] rd_ctrl = {29'h0, line_drv_reg, sw_drive_reg, 1'b0};
    wire [31:0] rd_wdog = {23'h0, 1'b0, wdog_sel_reg, 3'h0, wdog_en_reg};
    wire [31:0] rd_bod  = {25'h0, bod_rise_en_reg, bod_fall_en_reg, bod_rst_en_reg,
                           2'h0, bod_thr_reg};
    wire [31:0] rd_stat = {24'h0, running, i_line_in, i_bod_below, wdog_fired_reg,
                           1'b0, cause_reg};
    wire [31:0] rd_mux  = (i_addr == reset_seq_pkg::ADDR_CTRL)   ? rd_ctrl :
                          (i_addr == reset_seq_pkg::ADDR_WDOG)   ? rd_wdog :
                          (i_addr == reset_seq_pkg::ADDR_BOD)    ? rd_bod  :
                          (i_addr == reset_seq_pkg::ADDR_STATUS) ? rd_stat : 32'h0;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= 32'h0;
        end else if (i_ce) begin
            rdata_reg <= i_rd ? rd_mux : 32'h0;
        end
    end

    // Outputs
    assign o_line_out     = 1'b0;
    assign o_line_oe      = line_oe_reg;
    assign o_xtal_en      = (state_reg == reset_seq_pkg::ST_XTAL_WAIT) || running;
    assign o_logic_pwr_en = o_xtal_en;
    assign o_core_rst_n   = sync2_reg;
    assign o_ram_invalid  = ram_inv_reg;
    assign o_boot_vector  = reset_seq_pkg::RESET_VECTOR;
    assign o_bod_thr      = bod_thr_reg;
    assign o_bod_irq      = bod_irq_reg;
    assign o_rdata        = rdata_reg;

endmodule

// ===== verification/reset_seq_chk.sv
// Assertion checker for the reset and watchdog sequencer
module reset_seq_chk #(
    parameter int RC_CYC       = 20,
    parameter int XTAL_CYC     = 40,
    parameter int RISE_CYC     = 30,
    parameter int LINE_MIN_CYC = 8
) (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic        i_por_ok,
    input wire logic [1:0]  i_fuse_bod_thr,
    input wire logic        i_line_in,
    input wire logic        o_line_out,
    input wire logic        o_line_oe,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        o_xtal_en,
    input wire logic        o_logic_pwr_en,
    input wire logic        o_core_rst_n,
    input wire logic        o_ram_invalid,
    input wire logic [7:0]  o_boot_vector,
    input wire logic [1:0]  o_bod_thr,
    input wire logic        o_bod_irq
);
    int lo_cnt;
    int hi_cnt;
    int line_cnt;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lo_cnt   <= 0;
            hi_cnt   <= 0;
            line_cnt <= 0;
        end else begin
            lo_cnt   <= o_xtal_en ? 0 : lo_cnt + 1;
            hi_cnt   <= o_xtal_en ? hi_cnt + 1 : 0;
            line_cnt <= (i_line_in || o_line_oe) ? 0 : line_cnt + 1;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    AST_BOOT_VECTOR: assert property (o_boot_vector == 8'h38)
        else $error("boot vector wrong");
    AST_LINE_PULL_ONLY: assert property (o_line_oe |-> !o_line_out)
        else $error("reset line driven high");
    AST_RC_BEFORE_XTAL: assert property ($rose(o_xtal_en) |-> lo_cnt >= RC_CYC)
        else $error("crystal enabled too early");
    AST_PWR_WITH_XTAL: assert property (o_logic_pwr_en == o_xtal_en)
        else $error("logic power not with crystal");
    AST_XTAL_BEFORE_RUN: assert property ($rose(o_core_rst_n) |-> hi_cnt >= XTAL_CYC)
        else $error("core released too early");
    AST_REL_SYNC: assert property ($rose(o_core_rst_n) |-> $past(o_xtal_en, 2))
        else $error("core release not synchronised");
    AST_POR_DROP: assert property (!i_por_ok |=> !o_core_rst_n)
        else $error("supply drop did not reset");
    AST_SW_RESET: assert property (i_ce && i_wr && i_addr == reset_seq_pkg::ADDR_CTRL
        && i_wdata[reset_seq_pkg::CTRL_SW_RST] && o_core_rst_n |-> ##[1:4] !o_core_rst_n)
        else $error("software reset missing");
    AST_RAM_INVALID: assert property ($fell(o_core_rst_n) |-> ##[0:2] o_ram_invalid)
        else $error("ram not invalidated");
    AST_LINE_LOW: assert property (line_cnt >= RISE_CYC + LINE_MIN_CYC + 4 |-> !o_core_rst_n)
        else $error("low line did not reset");
    AST_FUSE_THR: assert property ($rose(o_xtal_en) |-> o_bod_thr == i_fuse_bod_thr)
        else $error("fuse threshold not loaded");
    AST_IRQ_PULSE: assert property (o_bod_irq |=> !o_bod_irq)
        else $error("brown-out irq too long");
    COV_RUN: cover property ($rose(o_core_rst_n));
    COV_IRQ: cover property (o_bod_irq);
    COV_LINE: cover property (line_cnt == LINE_MIN_CYC);
endmodule

bind reset_watchdog_sequencer reset_seq_chk #(
    .RC_CYC(RC_CYC), .XTAL_CYC(XTAL_CYC), .RISE_CYC(RISE_CYC), .LINE_MIN_CYC(LINE_MIN_CYC)
) i_chk (
    .i_core_clk, .i_rst_n, .i_ce, .i_por_ok, .i_fuse_bod_thr, .i_line_in, .o_line_out,
    .o_line_oe, .i_addr, .i_wdata, .i_wr, .o_xtal_en, .o_logic_pwr_en, .o_core_rst_n,
    .o_ram_invalid, .o_boot_vector, .o_bod_thr, .o_bod_irq
);

// ===== verification/reset_line_model.sv
// Shared reset line with pull-up, slow rise and other devices
module reset_line_model (
    input  wire logic       i_clk,
    input  wire logic       i_dev_out,
    input  wire logic       i_dev_oe,
    input  wire logic       i_other_pull,
    input  wire logic [7:0] i_rise_dly,
    output logic            o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rel_cnt = 8'h00;
    // Pull-up needs some cycles to lift the line after release
    always @(posedge i_clk) begin
        if (i_dev_oe || i_other_pull) begin
            rel_cnt <= 8'h00;
        end else if (rel_cnt < i_rise_dly) begin
            rel_cnt <= rel_cnt + 8'h01;
        end
    end
    // Others only sink the line, never drive it high
    assign o_line = (i_dev_oe ? i_dev_out : 1'b1) && !i_other_pull
        && rel_cnt >= i_rise_dly;
endmodule

// ===== verification/tb.sv
// Testbench for the reset and watchdog sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RS = 30;
    localparam int SW = 5;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        por_ok = 1;
    logic        bod = 1;
    logic        pull = 0;
    logic [7:0]  dly = 8'h01;
    logic        tick = 0;
    logic        slp = 0;
    logic        stall = 0;
    logic        wake = 0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 0;
    logic        rd = 0;
    logic [31:0] rdata;
    logic        line, lout, oe, xtal, core_n, ram_inv, irq, seen;
    logic [7:0]  vec;
    logic [1:0]  thr;
    int          mismatches = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n;
    initial forever #2 clk = ~clk;
    reset_watchdog_sequencer #(
        .RC_CYC(20), .XTAL_CYC(40), .RISE_CYC(RS), .SW_CYC(SW), .LINE_MIN_CYC(8)
    ) i_dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_por_ok(por_ok),
        .i_bod_below(bod), .i_fuse_bod_thr(2'h2), .i_line_in(line), .o_line_out(lout),
        .o_line_oe(oe), .i_tick32k(tick), .i_sleep(slp), .i_debug_stall(stall),
        .i_wake(wake), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_xtal_en(xtal), .o_logic_pwr_en(), .o_core_rst_n(core_n),
        .o_ram_invalid(ram_inv), .o_boot_vector(vec), .o_bod_thr(thr), .o_bod_irq(irq)
    );
    reset_line_model i_line (
        .i_clk(clk), .i_dev_out(lout), .i_dev_oe(oe), .i_other_pull(pull),
        .i_rise_dly(dly), .o_line(line)
    );
    task automatic tally_and_finish();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc  <= cyc + 1;
        tick <= (cyc % 4 == 3);
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1;
        step(1);
        wr <= 0;
        step(1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        addr <= a;
        rd   <= 1;
        step(1);
        rd <= 0;
        chk(nm, exp, rdata);
        step(1);
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim, input string nm);
        int k = 0;
        while (s !== v && k < lim) begin
            step(1);
            k++;
        end
        chk(nm, v, s);
    endtask
    initial begin
        step(10);
        rst_n <= 1;
        step(100);
        chk("xtal held", 0, xtal);
        chk("line driven", 1, oe);
        chk("fuse thr", 2'h2, thr);
        bod <= 0;
        wait_for(xtal, 1, 60, "xtal on");
        wait_for(core_n, 1, 100, "core run");
        chk("line released", 1, line);
        chk("vector", 8'h38, vec);
        chk("ram valid", 0, ram_inv);
        rdc(reset_seq_pkg::ADDR_CTRL, 32'h2, "ctrl");
        rdc(reset_seq_pkg::ADDR_WDOG, 32'hb1, "wdog");
        rdc(reset_seq_pkg::ADDR_BOD, 32'h12, "bod");
        rdc(reset_seq_pkg::ADDR_STATUS, 32'hc0, "status por");
        rdc(8'h10, 32'h0, "unmapped");
        for (int i = 0; i < 4; i++) begin
            wrr(reset_seq_pkg::ADDR_BOD, 32'h10 | i);
            chk("bod thr", i, thr);
        end
        wrr(reset_seq_pkg::ADDR_BOD, 32'h61);
        bod <= 1;
        wait_for(irq, 1, 10, "irq fall");
        step(4);
        bod <= 0;
        wait_for(irq, 1, 10, "irq rise");
        chk("no bod reset", 1, core_n);
        wrr(reset_seq_pkg::ADDR_BOD, 32'h11);
        bod <= 1;
        wait_for(core_n, 0, 10, "bod reset");
        bod <= 0;
        wait_for(core_n, 1, 200, "core run");
        rdc(reset_seq_pkg::ADDR_STATUS, 32'hc4, "status bod");
        wrr(reset_seq_pkg::ADDR_CTRL, 32'h6);
        chk("line held", 1, oe);
        step(40);
        chk("no self reset", 1, core_n);
        wrr(reset_seq_pkg::ADDR_CTRL, 32'h2);
        step(40);
        chk("line rose", 1, core_n);
        dly <= 8'd60;
        wrr(reset_seq_pkg::ADDR_CTRL, 32'h6);
        wrr(reset_seq_pkg::ADDR_CTRL, 32'h2);
        wait_for(core_n, 0, RS + 20, "rise timeout");
        dly <= 8'h01;
        wait_for(core_n, 1, 200, "core run");
        rdc(reset_seq_pkg::ADDR_STATUS, 32'hc5, "status line");
        pull <= 1;
        step(4);
        pull <= 0;
        step(20);
        chk("short pulse", 1, core_n);
        pull <= 1;
        wait_for(core_n, 0, 20, "ext reset");
        step(40);
        chk("ext held", 0, core_n);
        pull <= 0;
        wait_for(core_n, 1, 200, "core run");
        rdc(reset_seq_pkg::ADDR_STATUS, 32'hc1, "status ext");
        wrr(reset_seq_pkg::ADDR_CTRL, 32'h3);
        wait_for(oe, 1, 5, "sw drive");
        chk("ram invalid", 1, ram_inv);
        n = 0;
        while (oe === 1'b1 && n < 50) begin
            step(1);
            n++;
        end
        chk("sw pulse", SW, n);
        wait_for(core_n, 1, 200, "core run");
        rdc(reset_seq_pkg::ADDR_STATUS, 32'hc2, "status sw");
        wrr(reset_seq_pkg::ADDR_CTRL, 32'h0);
        wrr(reset_seq_pkg::ADDR_CTRL, 32'h1);
        seen = 0;
        repeat (20) begin
            seen |= oe;
            step(1);
        end
        chk("sw no drive", 0, seen);
        wait_for(core_n, 1, 200, "core run");
        wrr(reset_seq_pkg::ADDR_WDOG, 32'h1);
        step(400);
        slp <= 1;
        step(600);
        slp <= 0;
        stall <= 1;
        step(600);
        stall <= 0;
        step(400);
        chk("wdog paused", 1, core_n);
        wrr(reset_seq_pkg::ADDR_WDOG, 32'h101);
        step(800);
        chk("wdog restarted", 1, core_n);
        wait_for(core_n, 0, 400, "wdog expiry");
        wait_for(core_n, 1, 200, "core run");
        rdc(reset_seq_pkg::ADDR_WDOG, 32'hb1, "wdog default");
        rdc(reset_seq_pkg::ADDR_STATUS, 32'hd3, "status wdog");
        wrr(reset_seq_pkg::ADDR_STATUS, 32'h10);
        rdc(reset_seq_pkg::ADDR_STATUS, 32'hc3, "fired cleared");
        wrr(reset_seq_pkg::ADDR_WDOG, 32'h0);
        wake <= 1;
        step(1);
        wake <= 0;
        step(1);
        rdc(reset_seq_pkg::ADDR_WDOG, 32'hb1, "wdog wake");
        por_ok <= 0;
        step(3);
        chk("por drop", 0, core_n);
        por_ok <= 1;
        step(5);
        chk("por drive", 1, oe);
        wait_for(core_n, 1, 200, "core run");
        rdc(reset_seq_pkg::ADDR_STATUS, 32'hc0, "status por");
        tally_and_finish();
    end
endmodule
